// File: rtl/ccl_pkg.sv
package ccl_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_ADC_CONTROL_B = 10'h07B;
  localparam logic [9:0] IDX_DIG_IN_DIS_0  = 10'h07E;
  localparam logic [9:0] IDX_CMP_CTRL_STAT = 10'h050;
  localparam logic [9:0] IDX_INT_STATUS    = 10'h080;
  localparam logic [9:0] IDX_INT_MASK      = 10'h081;

  // Comparator control and status fields
  localparam int CS_POWER_OFF = 7;
  localparam int CS_IREF_SEL  = 6;
  localparam int CS_RESULT    = 5;
  localparam int CS_IRQ_FLAG  = 4;
  localparam int CS_IRQ_EN    = 3;
  localparam int CS_CAP_EN    = 2;
  localparam int CS_MODE_LO   = 0;

  // Control register B fields
  localparam int  CB_MUX_EN   = 6;
  localparam int  CB_LEVEL_LO = 4;
  localparam logic [7:0] CB_RW_MASK = 8'hF7;

  // Digital input disable fields
  localparam int DD_POS_OFF = 7;
  localparam int DD_NEG_OFF = 6;

  // Interrupt status layout
  localparam int IS_SELECTED = 0;
  localparam int IS_RISE     = 1;
  localparam int IS_FALL     = 2;
  localparam int IS_W        = 3;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef enum logic [1:0] {
    CCL_MODE_TOGGLE = 2'h0,
    CCL_MODE_RSVD   = 2'h1,
    CCL_MODE_FALL   = 2'h2,
    CCL_MODE_RISE   = 2'h3
  } ccl_mode_t;

  localparam logic [1:0] REF_SRC_INTERNAL = 2'h3;
  localparam int         LAST_CHANNEL     = 10;
endpackage : ccl_pkg

// File: rtl/ccl_sync_edge.sv
`timescale 1ns/100ps
`default_nettype none
module ccl_sync_edge (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic raw_in,
  output logic      level,
  output logic      rise,
  output logic      fall,
  output logic      toggle
);
  typedef struct packed {
    logic stage1;
    logic stage2;
    logic prev;
  } ccl_sync_t;

  ccl_sync_t st;
  ccl_sync_t next_st;

  // Two-flop synchroniser plus a delayed copy for edge detection
  always_comb begin
    next_st        = st;
    next_st.stage1 = raw_in;
    next_st.stage2 = st.stage1;
    next_st.prev   = st.stage2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level  = st.stage2;
  assign rise   = st.stage2 & ~st.prev;
  assign fall   = ~st.stage2 & st.prev;
  assign toggle = st.stage2 ^ st.prev;
endmodule : ccl_sync_edge
`default_nettype wire

// File: rtl/ccl_comparator_ctrl.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module ccl_comparator_ctrl #(
  parameter int          NCH     = 11,
  parameter int          VW      = 12,
  parameter logic [11:0] REF_MV  = 12'hA00
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [NCH*VW-1:0] adc_pin_mv,
  input  wire logic [VW-1:0]     cmp_pos_pin,
  input  wire logic [VW-1:0]     cmp_neg_pin,
  input  wire logic              converter_enable,
  input  wire logic [4:0]        channel_select,
  input  wire logic [1:0]        ref_source_field,
  input  wire logic              global_irq_enable,
  input  wire logic              irq_vector_ack,
  input  wire logic              pos_pin_port_in,
  input  wire logic              neg_pin_port_in,
  output logic                   cmp_raw_result,
  output logic                   cmp_power_down,
  output logic                   cmp_irq_req,
  output logic                   capture_in,
  output logic                   pos_pin_input_off,
  output logic                   neg_pin_input_off,
  output logic                   pos_pin_read,
  output logic                   neg_pin_read,
  output logic                   irq
);
  typedef struct packed {
    logic [7:0]              adcb;
    logic [7:0]              didr;
    logic                    power_off;
    logic                    iref_sel;
    logic                    irq_flag;
    logic                    irq_en;
    logic                    cap_en;
    logic [1:0]              mode;
    logic [ccl_pkg::IS_W-1:0] int_status;
    logic [ccl_pkg::IS_W-1:0] int_mask;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic                    raw_result;
    logic                    irq_req;
    logic                    capture;
    logic                    pos_read;
    logic                    neg_read;
    logic                    irq;
  } ccl_state_t;

  ccl_state_t st;
  ccl_state_t next_st;

  logic          cmp_result;
  logic          edge_rise;
  logic          edge_fall;
  logic          edge_toggle;
  logic          compare_now;
  logic          evt;
  logic          access;
  logic          wr_acc;
  logic [9:0]    idx;
  logic [VW-1:0] pos_mv;
  logic [VW-1:0] neg_mv;

  function automatic logic [VW-1:0] pick_pos(
    input logic              mux_en,
    input logic              conv_en,
    input logic [4:0]        chan,
    input logic [NCH*VW-1:0] pins,
    input logic [VW-1:0]     dedicated
  );
    logic [VW-1:0] v;
    v = dedicated;
    if (mux_en && !conv_en) begin
      if (int'(chan) <= ccl_pkg::LAST_CHANNEL && int'(chan) < NCH) begin
        v = pins[int'(chan)*VW +: VW];
      end else begin
        v = '0;
      end
    end
    return v;
  endfunction : pick_pos

  function automatic logic [VW-1:0] pick_neg(
    input logic          iref,
    input logic [1:0]    src,
    input logic [1:0]    level,
    input logic [VW-1:0] dedicated
  );
    logic [VW-1:0] v;
    v = dedicated;
    if (iref) begin
      if (src == ccl_pkg::REF_SRC_INTERNAL) begin
        v = VW'(REF_MV) >> level;
      end else begin
        v = '1;
      end
    end
    return v;
  endfunction : pick_neg

  function automatic logic [31:0] read_word(input ccl_state_t s, input logic res,
                                            input logic [9:0] i);
    logic [31:0] w;
    w = '0;
    unique case (i)
      ccl_pkg::IDX_ADC_CONTROL_B: w[7:0] = s.adcb;
      ccl_pkg::IDX_DIG_IN_DIS_0:  w[7:0] = s.didr;
      ccl_pkg::IDX_CMP_CTRL_STAT: w[7:0] = {s.power_off, s.iref_sel, res, s.irq_flag,
                                            s.irq_en, s.cap_en, s.mode};
      ccl_pkg::IDX_INT_STATUS:    w[ccl_pkg::IS_W-1:0] = s.int_status;
      ccl_pkg::IDX_INT_MASK:      w[ccl_pkg::IS_W-1:0] = s.int_mask;
      default:                    w = '0;
    endcase
    return w;
  endfunction : read_word

  function automatic logic mapped(input logic [9:0] i);
    return i == ccl_pkg::IDX_ADC_CONTROL_B || i == ccl_pkg::IDX_DIG_IN_DIS_0 ||
           i == ccl_pkg::IDX_CMP_CTRL_STAT || i == ccl_pkg::IDX_INT_STATUS ||
           i == ccl_pkg::IDX_INT_MASK;
  endfunction : mapped

  // Analog input selection and comparison
  assign pos_mv = pick_pos(st.adcb[ccl_pkg::CB_MUX_EN], converter_enable, channel_select,
                           adc_pin_mv, cmp_pos_pin);
  assign neg_mv = pick_neg(st.iref_sel, ref_source_field,
                           st.adcb[ccl_pkg::CB_LEVEL_LO +: 2], cmp_neg_pin);
  assign compare_now = !st.power_off && (pos_mv > neg_mv);

  ccl_sync_edge u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .raw_in  (compare_now),
    .level   (cmp_result),
    .rise    (edge_rise),
    .fall    (edge_fall),
    .toggle  (edge_toggle)
  );

  // Event selection by edge mode
  always_comb begin
    unique case (ccl_pkg::ccl_mode_t'(st.mode))
      ccl_pkg::CCL_MODE_TOGGLE: evt = edge_toggle;
      ccl_pkg::CCL_MODE_FALL:   evt = edge_fall;
      ccl_pkg::CCL_MODE_RISE:   evt = edge_rise;
      ccl_pkg::CCL_MODE_RSVD:   evt = 1'b0;
    endcase
  end

  assign idx    = paddr[11:2];
  assign access = psel && penable && st.pready;
  assign wr_acc = access && pwrite && mapped(idx) && paddr[1:0] == 2'h0;

  always_comb begin
    next_st = st;
    // One wait state per access
    next_st.pready  = psel && penable && !st.pready;
    next_st.pslverr = psel && penable && !st.pready &&
                      (!mapped(idx) || paddr[1:0] != 2'h0);
    if (psel && penable && !st.pready) begin
      next_st.prdata = (pwrite || paddr[1:0] != 2'h0) ? '0 : read_word(st, cmp_result, idx);
    end
    if (wr_acc) begin
      unique case (idx)
        ccl_pkg::IDX_ADC_CONTROL_B: next_st.adcb = pwdata[7:0] & ccl_pkg::CB_RW_MASK;
        ccl_pkg::IDX_DIG_IN_DIS_0:  next_st.didr = pwdata[7:0];
        ccl_pkg::IDX_CMP_CTRL_STAT: begin
          next_st.power_off = pwdata[ccl_pkg::CS_POWER_OFF];
          next_st.iref_sel  = pwdata[ccl_pkg::CS_IREF_SEL];
          next_st.irq_en    = pwdata[ccl_pkg::CS_IRQ_EN];
          next_st.cap_en    = pwdata[ccl_pkg::CS_CAP_EN];
          next_st.mode      = pwdata[ccl_pkg::CS_MODE_LO +: 2];
          if (pwdata[ccl_pkg::CS_IRQ_FLAG]) begin
            next_st.irq_flag = 1'b0;
          end
        end
        ccl_pkg::IDX_INT_STATUS: next_st.int_status = st.int_status &
                                                      ~pwdata[ccl_pkg::IS_W-1:0];
        ccl_pkg::IDX_INT_MASK:   next_st.int_mask = pwdata[ccl_pkg::IS_W-1:0];
        default: next_st.int_mask = st.int_mask;
      endcase
    end
    if (irq_vector_ack) begin
      next_st.irq_flag = 1'b0;
    end
    // Hardware set wins over any clear in the same cycle
    if (evt) begin
      next_st.irq_flag = 1'b1;
    end
    next_st.int_status = next_st.int_status | {edge_fall, edge_rise, evt};
    next_st.irq_req    = next_st.irq_flag && next_st.irq_en && global_irq_enable;
    next_st.irq        = |(next_st.int_status & next_st.int_mask);
    next_st.raw_result = compare_now;
    next_st.capture    = next_st.cap_en && cmp_result;
    next_st.pos_read   = pos_pin_port_in && !next_st.didr[ccl_pkg::DD_POS_OFF];
    next_st.neg_read   = neg_pin_port_in && !next_st.didr[ccl_pkg::DD_NEG_OFF];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata            = st.prdata;
  assign pready            = st.pready;
  assign pslverr           = st.pslverr;
  assign cmp_raw_result    = st.raw_result;
  assign cmp_power_down    = st.power_off;
  assign cmp_irq_req       = st.irq_req;
  assign capture_in        = st.capture;
  assign pos_pin_input_off = st.didr[ccl_pkg::DD_POS_OFF];
  assign neg_pin_input_off = st.didr[ccl_pkg::DD_NEG_OFF];
  assign pos_pin_read      = st.pos_read;
  assign neg_pin_read      = st.neg_read;
  assign irq               = st.irq;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_power_off_low: assert property (st.power_off |=> !st.raw_result)
    else $error("raw result high while powered off");
  a_sync_latency: assert property (cmp_result == $past(st.raw_result))
    else $error("synchronised result not one cycle behind raw");
  a_flag_on_event: assert property (evt |=> st.irq_flag)
    else $error("event did not set flag");
  a_flag_zero_write: assert property (wr_acc && idx == ccl_pkg::IDX_CMP_CTRL_STAT &&
      !pwdata[ccl_pkg::CS_IRQ_FLAG] && !irq_vector_ack && st.irq_flag |=> st.irq_flag)
    else $error("writing zero cleared flag");
  a_flag_ack_clear: assert property (irq_vector_ack && !evt |=> !st.irq_flag)
    else $error("vector ack did not clear flag");
  a_irq_req_gate: assert property (cmp_irq_req |-> st.irq_flag && st.irq_en)
    else $error("request without flag and enable");
  a_rsvd_mode: assert property (st.mode == 2'h1 && !st.irq_flag && $stable(st.mode)
      |=> !st.irq_flag)
    else $error("reserved mode raised flag");
  a_rise_mode: assert property (st.mode == 2'h3 && edge_fall |-> !evt)
    else $error("falling edge counted in rising mode");
  a_capture_off: assert property (!st.cap_en |-> !capture_in)
    else $error("capture routed while disabled");
  a_pin_disable: assert property (st.didr[ccl_pkg::DD_POS_OFF] ##1
      st.didr[ccl_pkg::DD_POS_OFF] |-> !pos_pin_read)
    else $error("disabled pin reads one");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");

  a_raw_follows: assert property ($past(presetn) |->
      st.raw_result == $past(compare_now))
    else $error("raw result not one cycle behind compare");
  a_pos_dedicated: assert property (!st.adcb[ccl_pkg::CB_MUX_EN] ||
      converter_enable |-> pos_mv == cmp_pos_pin)
    else $error("dedicated positive pin not selected");
  a_pos_channel: assert property (st.adcb[ccl_pkg::CB_MUX_EN] && !converter_enable &&
      channel_select == 5'h00 |-> pos_mv == adc_pin_mv[VW-1:0])
    else $error("channel zero not routed to positive input");
  a_neg_dedicated: assert property (!st.iref_sel |-> neg_mv == cmp_neg_pin)
    else $error("dedicated negative pin not selected");
  a_neg_full_ref: assert property (st.iref_sel &&
      ref_source_field == ccl_pkg::REF_SRC_INTERNAL &&
      st.adcb[ccl_pkg::CB_LEVEL_LO +: 2] == 2'h0 |-> neg_mv == VW'(REF_MV))
    else $error("full reference not selected");
  a_neg_eighth_ref: assert property (st.iref_sel &&
      ref_source_field == ccl_pkg::REF_SRC_INTERNAL &&
      st.adcb[ccl_pkg::CB_LEVEL_LO +: 2] == 2'h3 |-> neg_mv == (VW'(REF_MV) >> 3))
    else $error("eighth reference not selected");

  a_req_global: assert property (cmp_irq_req |-> $past(global_irq_enable))
    else $error("request without global enable");
  a_req_raise: assert property (st.irq_flag && st.irq_en && global_irq_enable &&
      !irq_vector_ack && !wr_acc |=> cmp_irq_req)
    else $error("enabled pending flag gave no request");
  a_flag_w1c: assert property (wr_acc && idx == ccl_pkg::IDX_CMP_CTRL_STAT &&
      pwdata[ccl_pkg::CS_IRQ_FLAG] && !evt |=> !st.irq_flag)
    else $error("writing one did not clear flag");
  a_fall_mode: assert property (st.mode == 2'h2 && edge_rise |-> !evt)
    else $error("rising edge counted in falling mode");
  a_toggle_mode: assert property (st.mode == 2'h0 |-> evt == edge_toggle)
    else $error("toggle mode missed an edge");
  a_int_sticky: assert property (st.int_status[ccl_pkg::IS_SELECTED] && !wr_acc
      |=> st.int_status[ccl_pkg::IS_SELECTED])
    else $error("event status bit lost without a write");

  a_capture_on: assert property (st.cap_en && cmp_result && !wr_acc
      |=> capture_in)
    else $error("capture input not routed while enabled");
  a_pos_read_on: assert property (!st.didr[ccl_pkg::DD_POS_OFF] &&
      pos_pin_port_in && !wr_acc |=> pos_pin_read)
    else $error("enabled positive pin reads zero");
  a_neg_read_on: assert property (!st.didr[ccl_pkg::DD_NEG_OFF] &&
      neg_pin_port_in && !wr_acc |=> neg_pin_read)
    else $error("enabled negative pin reads zero");
  a_didr_write: assert property (wr_acc && idx == ccl_pkg::IDX_DIG_IN_DIS_0
      |=> pos_pin_input_off == $past(pwdata[ccl_pkg::DD_POS_OFF]))
    else $error("input disable write not taken");
  a_level_write: assert property (wr_acc && idx == ccl_pkg::IDX_ADC_CONTROL_B
      |=> st.adcb[ccl_pkg::CB_LEVEL_LO +: 2] == $past(pwdata[ccl_pkg::CB_LEVEL_LO +: 2]))
    else $error("reference level write not taken");
  a_power_write: assert property (wr_acc && idx == ccl_pkg::IDX_CMP_CTRL_STAT
      |=> cmp_power_down == $past(pwdata[ccl_pkg::CS_POWER_OFF]))
    else $error("power off write not taken");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("error reply without ready");

  c_rise_flag: cover property (st.mode == 2'h3 && edge_rise ##1 st.irq_flag);
  c_fall_flag: cover property (st.mode == 2'h2 && edge_fall ##1 st.irq_flag);
  c_toggle_req: cover property (edge_toggle ##[1:3] cmp_irq_req);
  c_capture: cover property (st.cap_en && cmp_result ##1 capture_in);
  c_ack_clear: cover property (irq_vector_ack ##1 !st.irq_flag);
endmodule : ccl_comparator_ctrl
`default_nettype wire

// File: sim/ccl_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module ccl_cpu_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       cmp_irq_req,
  input  wire logic       ack_en,
  input  wire logic [3:0] dly,
  output logic            irq_vector_ack
);
  logic [3:0] cnt;

  // Vector entry after dly cycles of pending request, one pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt            <= 4'h0;
      irq_vector_ack <= 1'b0;
    end else begin
      irq_vector_ack <= ack_en && cmp_irq_req && !irq_vector_ack && cnt == dly;
      if (!cmp_irq_req || irq_vector_ack) begin
        cnt <= 4'h0;
      end else if (cnt != dly) begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : ccl_cpu_model
`default_nettype wire

// File: sim/ccl_comparator_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module ccl_comparator_ctrl_tb_top;
  localparam logic [9:0] CB = ccl_pkg::IDX_ADC_CONTROL_B;
  localparam logic [9:0] DD = ccl_pkg::IDX_DIG_IN_DIS_0;
  localparam logic [9:0] CS = ccl_pkg::IDX_CMP_CTRL_STAT;
  localparam logic [9:0] IS = ccl_pkg::IDX_INT_STATUS;
  localparam logic [9:0] IM = ccl_pkg::IDX_INT_MASK;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]  paddr, ppin, npin;
  logic [31:0]  pwdata, prdata, seed;
  logic [131:0] adc;
  logic         conv_en, gie, ack, ack_en, pin_p, pin_n;
  logic [4:0]   chan;
  logic [1:0]   rsrc;
  logic [3:0]   dly;
  logic         raw, pdn, req, cap, poff, noff, prd, nrd, irq;
  logic [33:0]  expq[$];
  logic [9:0]   regs[5] = '{CB, DD, CS, IS, IM};
  logic [1:0]   modes[4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  logic [3:0]   dlys[2] = '{4'h0, 4'h9};
  int           mismatches, cmp_count, cyc;

  ccl_comparator_ctrl uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_pin_mv(adc), .cmp_pos_pin(ppin), .cmp_neg_pin(npin), .converter_enable(conv_en),
    .channel_select(chan), .ref_source_field(rsrc), .global_irq_enable(gie),
    .irq_vector_ack(ack), .pos_pin_port_in(pin_p), .neg_pin_port_in(pin_n),
    .cmp_raw_result(raw), .cmp_power_down(pdn), .cmp_irq_req(req), .capture_in(cap),
    .pos_pin_input_off(poff), .neg_pin_input_off(noff), .pos_pin_read(prd),
    .neg_pin_read(nrd), .irq(irq));

  ccl_cpu_model cpu (.pclk(pclk), .presetn(presetn), .cmp_irq_req(req), .ack_en(ack_en),
    .dly(dly), .irq_vector_ack(ack));

  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic print_verdict();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  task automatic fail(input string m);
    mismatches++;
    $display("Error %0t %s", $time, m);
  endtask : fail

  task automatic chk(input logic g, input logic e);
    cmp_count++;
    if (g !== e) fail("output level wrong");
  endtask : chk

  task automatic cmp_bus(input logic [33:0] e);
    cmp_count++;
    if (pslverr !== e[32] || (e[33] && prdata !== e[31:0])) fail("bus reply wrong");
  endtask : cmp_bus

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt

  // One APB transfer; for reads d is the expected byte
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d, input logic er);
    expq.push_back({!w, er, 24'h0, d});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {a, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic setcmp(input logic b);
    logic [11:0] r;
    r = 12'(xs() % 500) + 12'h001;
    @(posedge pclk);
    npin <= 12'h7D0;
    ppin <= b ? 12'h7D0 + r : 12'h7D0 - r;
    wt(5);
  endtask : setcmp

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (expq.size() == 0) fail("unexpected reply");
      else cmp_bus(expq.pop_front());
    end
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc > 5000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    logic [1:0]  m;
    logic        f;
    logic [11:0] v;
    {psel, penable, pwrite, conv_en, gie, ack_en, pin_p, pin_n, presetn} = '0;
    {paddr, pwdata, adc, ppin, npin, chan, rsrc, dly} = '0;
    seed = 32'h1843_e38a;
    wt(8);
    presetn <= 1'b1;
    foreach (regs[i]) apb(1'b0, regs[i], 8'h00, 1'b0);
    apb(1'b0, 10'h3FF, 8'h00, 1'b1);
    apb(1'b1, CB, 8'hFF, 1'b0);
    apb(1'b0, CB, 8'hF7, 1'b0);
    pin_p <= 1'b1;
    pin_n <= 1'b1;
    apb(1'b1, DD, 8'hC0, 1'b0);
    apb(1'b0, DD, 8'hC0, 1'b0);
    chk(poff, 1'b1);
    chk(nrd, 1'b0);
    chk(prd, 1'b0);
    apb(1'b1, DD, 8'h40, 1'b0);
    wt(2);
    chk(prd, 1'b1);
    chk(noff, 1'b1);
    apb(1'b1, CB, 8'h00, 1'b0);
    setcmp(1'b0);
    foreach (modes[i]) begin
      m = modes[i];
      apb(1'b1, CS, {6'h04, m}, 1'b0);
      setcmp(1'b1);
      f = (m == 2'h0 || m == 2'h3);
      apb(1'b0, CS, {2'h0, 1'b1, f, 2'h0, m}, 1'b0);
      apb(1'b1, CS, {6'h04, m}, 1'b0);
      setcmp(1'b0);
      f = (m == 2'h0 || m == 2'h2);
      apb(1'b0, CS, {3'h0, f, 2'h0, m}, 1'b0);
    end
    apb(1'b1, CS, 8'h1B, 1'b0);
    setcmp(1'b1);
    chk(req, 1'b0);
    apb(1'b1, CS, 8'h0B, 1'b0);
    apb(1'b0, CS, 8'h3B, 1'b0);
    gie <= 1'b1;
    foreach (dlys[i]) begin
      dly <= dlys[i];
      setcmp(1'b0);
      setcmp(1'b1);
      chk(req, 1'b1);
      ack_en <= 1'b1;
      wt(14);
      chk(req, 1'b0);
      ack_en <= 1'b0;
    end
    apb(1'b0, CS, 8'h2B, 1'b0);
    apb(1'b1, CS, 8'h13, 1'b0);
    apb(1'b1, IS, 8'h07, 1'b0);
    apb(1'b1, IM, 8'h01, 1'b0);
    apb(1'b0, IM, 8'h01, 1'b0);
    setcmp(1'b0);
    chk(irq, 1'b0);
    apb(1'b0, IS, 8'h04, 1'b0);
    setcmp(1'b1);
    chk(irq, 1'b1);
    apb(1'b0, IS, 8'h07, 1'b0);
    apb(1'b1, IM, 8'h00, 1'b0);
    wt(2);
    chk(irq, 1'b0);
    apb(1'b1, IS, 8'h07, 1'b0);
    apb(1'b0, IS, 8'h00, 1'b0);
    apb(1'b1, CS, 8'h04, 1'b0);
    setcmp(1'b0);
    chk(cap, 1'b0);
    setcmp(1'b1);
    chk(cap, 1'b1);
    apb(1'b1, CS, 8'h00, 1'b0);
    wt(2);
    chk(cap, 1'b0);
    apb(1'b1, CS, 8'h80, 1'b0);
    wt(3);
    chk(pdn, 1'b1);
    chk(raw, 1'b0);
    apb(1'b1, CS, 8'h00, 1'b0);
    wt(3);
    chk(pdn, 1'b0);
    chk(raw, 1'b1);
    apb(1'b1, CB, 8'h40, 1'b0);
    npin <= 12'hBB8;
    ppin <= 12'h000;
    for (int c = 0; c <= ccl_pkg::LAST_CHANNEL; c++) begin
      for (int k = 0; k < 11; k++) begin
        adc[k*12 +: 12] <= (k == c) ? 12'hBB9 + 12'(xs() % 500) : 12'(xs() % 2000);
      end
      chan <= 5'(c);
      wt(3);
      chk(raw, 1'b1);
    end
    conv_en <= 1'b1;
    wt(3);
    chk(raw, 1'b0);
    conv_en <= 1'b0;
    apb(1'b1, CB, 8'h00, 1'b0);
    wt(3);
    chk(raw, 1'b0);
    rsrc <= 2'h3;
    npin <= 12'hFFF;
    apb(1'b1, CS, 8'h40, 1'b0);
    for (int l = 0; l < 4; l++) begin
      apb(1'b1, CB, {2'h0, 2'(l), 4'h0}, 1'b0);
      apb(1'b0, CB, {2'h0, 2'(l), 4'h0}, 1'b0);
      v = 12'hA00 >> l;
      ppin <= v + 12'h001;
      wt(3);
      chk(raw, 1'b1);
      ppin <= v - 12'h001;
      wt(3);
      chk(raw, 1'b0);
    end
    apb(1'b1, CS, 8'h00, 1'b0);
    ppin <= 12'hA01;
    wt(3);
    chk(raw, 1'b0);
    presetn <= 1'b0;
    wt(2);
    presetn <= 1'b1;
    foreach (regs[i]) apb(1'b0, regs[i], 8'h00, 1'b0);
    chk(prd, 1'b1);
    chk(noff, 1'b0);
    wt(4);
    print_verdict();
  end
endmodule : ccl_comparator_ctrl_tb_top
`default_nettype wire
